// ### bench/ptd_regs_tb.sv
// Purpose: self-checking bench for the test and debug register bank
// Assumes: one-cycle Wishbone answer; two-stage comparator synchroniser
// Notes:   waits on ack are bounded; a lost ack ends the run
`timescale 1ns/10ps
`default_nettype none
module ptd_regs_tb;
  import ptd_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [9:0]  adr_i = '0;
  logic [3:0]  sel_i = '0;
  logic [31:0] dat_i = '0, dat_o, q;
  logic        ack_o;
  logic [6:0]  comp_raw_i = 7'h55, debounce_in_o;
  logic [2:0]  bus_supply_state_i = '0, charger_state_i = '0;
  logic [3:0]  main_power_state_i = '0;
  logic        key_unlocked_i = 1'b0, loop_locked_i = 1'b0;
  logic [3:0]  loop_tracking_gain_i = 4'h9, loop_gain_o;
  logic [1:0]  loop_bias_setting_o, loop_pole_adjust_o;
  logic [2:0]  pwm_force_clear_i = '0, buck_pwm_force_o;
  int          err_total = 0;
  int          tests_run = 0;

  always #50 clk_i = ~clk_i;

  ptd_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .comp_raw_i(comp_raw_i), .debounce_in_o(debounce_in_o),
    .bus_supply_state_i(bus_supply_state_i),
    .charger_state_i(charger_state_i),
    .main_power_state_i(main_power_state_i),
    .key_unlocked_i(key_unlocked_i), .loop_locked_i(loop_locked_i),
    .loop_tracking_gain_i(loop_tracking_gain_i), .loop_gain_o(loop_gain_o),
    .loop_bias_setting_o(loop_bias_setting_o),
    .loop_pole_adjust_o(loop_pole_adjust_o),
    .pwm_force_clear_i(pwm_force_clear_i),
    .buck_pwm_force_o(buck_pwm_force_o));

  task automatic summarize();
    if (err_total == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] idx,
                    input logic [15:0] d);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= 4'h3;
    dat_i <= {16'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 16);
    if (ack_o !== 1'b1) begin
      err_total++;
      summarize();
    end else begin
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
    end
  endtask

  // comparator bit map into the register's force field
  function automatic logic [31:0] cmap(input logic [6:0] v);
    return {16'h0, v[6:4], 1'b0, v[3:0], 8'h00};
  endfunction

  task automatic t_reset_vals();
    wb(1'b0, PTD_IDX_LOOP_TEST, 16'h0);
    chk(q, 32'h1200);
    chk(loop_pole_adjust_o, 2'h0);
    chk(buck_pwm_force_o, 3'h0);
    wb(1'b0, 8'h10, 16'h0);
    chk(q, 32'h0);
    wb(1'b1, PTD_IDX_SM_READ, 16'hffff);
    wb(1'b0, PTD_IDX_SM_READ, 16'h0);
    chk(q, 32'h0);
  endtask

  task automatic t_compare();
    wb(1'b1, PTD_IDX_COMP_OVR, 16'h4a00);
    wb(1'b0, PTD_IDX_COMP_OVR, 16'h0);
    chk(q, cmap(7'h55));
    chk(debounce_in_o, 7'h55);
    wb(1'b1, PTD_IDX_OVR_CTRL, 16'h0001);
    repeat (3) @(posedge clk_i);
    chk(debounce_in_o, 7'h2a);
    comp_raw_i <= 7'h0f;
    repeat (4) @(posedge clk_i);
    chk(debounce_in_o, 7'h2a);
    wb(1'b0, PTD_IDX_COMP_OVR, 16'h0);
    chk(q, cmap(7'h0f));
    wb(1'b1, PTD_IDX_OVR_CTRL, 16'h0000);
    repeat (3) @(posedge clk_i);
    chk(debounce_in_o, 7'h0f);
  endtask

  task automatic t_states();
    logic [2:0] bc [5] = '{3'h1, 3'h5, 3'h4, 3'h2, 3'h6};
    logic [3:0] mc [4] = '{4'h2, 4'hd, 4'hc, 4'hf};
    for (int i = 0; i < 7; i++) begin
      bus_supply_state_i <= bc[i % 5];
      charger_state_i    <= i[2:0];
      main_power_state_i <= mc[i % 4];
      wb(1'b0, PTD_IDX_SM_READ, 16'h0);
      chk(q, {21'h0, bc[i % 5], 1'b0, i[2:0], mc[i % 4]});
    end
  endtask

  task automatic t_loop();
    repeat (3) @(posedge clk_i);
    chk(loop_gain_o, 4'h0);
    loop_locked_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(loop_gain_o, 4'h9);
    loop_locked_i <= 1'b0;
    wb(1'b1, PTD_IDX_LOOP_TEST, 16'h01c0);
    wb(1'b0, PTD_IDX_LOOP_TEST, 16'h0);
    chk(q, 32'h1200);
    key_unlocked_i <= 1'b1;
    wb(1'b1, PTD_IDX_LOOP_TEST, 16'h01c0);
    wb(1'b0, PTD_IDX_LOOP_TEST, 16'h0);
    chk(q, 32'h01c0);
    chk({loop_bias_setting_o, loop_pole_adjust_o}, 4'h7);
    repeat (2) @(posedge clk_i);
    chk(loop_gain_o, 4'h9);
  endtask

  task automatic t_buck();
    wb(1'b1, PTD_IDX_BUCK_ONE, 16'h0010);
    wb(1'b1, PTD_IDX_BUCK_THR, 16'h0010);
    wb(1'b1, PTD_IDX_BUCK_FOUR, 16'h0010);
    chk(buck_pwm_force_o, 3'h7);
    wb(1'b0, PTD_IDX_BUCK_THR, 16'h0);
    chk(q, 32'h0010);
    pwm_force_clear_i <= 3'b010;
    @(posedge clk_i);
    pwm_force_clear_i <= 3'b000;
    repeat (2) @(posedge clk_i);
    chk(buck_pwm_force_o, 3'h5);
    // clear held across the write's take edge must beat the write
    pwm_force_clear_i <= 3'b001;
    wb(1'b1, PTD_IDX_BUCK_ONE, 16'h0010);
    pwm_force_clear_i <= 3'b000;
    chk(buck_pwm_force_o, 3'h4);
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_vals();
    t_compare();
    t_states();
    t_loop();
    t_buck();
    summarize();
  end
endmodule
`default_nettype wire

// ### design/ptd_pkg.sv
// Purpose: constants for the test and debug register bank
// Assumes: word-indexed registers, byte address is four times the index
// Notes:   field reset values and write-side field positions live here; readback words hard-code theirs
package ptd_pkg;

  // register indices (byte address = index * 4)
  localparam logic [7:0] PTD_IDX_COMP_OVR  = 8'he7;
  localparam logic [7:0] PTD_IDX_SM_READ   = 8'he9;
  localparam logic [7:0] PTD_IDX_LOOP_TEST = 8'hea;
  localparam logic [7:0] PTD_IDX_OVR_CTRL  = 8'hec;
  localparam logic [7:0] PTD_IDX_BUCK_ONE  = 8'hf8;
  localparam logic [7:0] PTD_IDX_BUCK_THR  = 8'hfa;
  localparam logic [7:0] PTD_IDX_BUCK_FOUR = 8'hfb;

  localparam int PTD_ADR_W  = 10;
  localparam int PTD_DAT_W  = 32;
  localparam int PTD_GAIN_W = 4;
  localparam int PTD_NCOMP  = 7;

  // comparator force field, bits 15:13 and 11:8
  localparam int PTD_COMP_HI_LSB = 13;
  localparam int PTD_COMP_LO_LSB = 8;
  // state readback fields
  localparam int PTD_BUS_ST_LSB  = 8;
  localparam int PTD_CHG_ST_LSB  = 4;
  localparam int PTD_MAIN_ST_LSB = 0;
  // loop test fields
  localparam int PTD_TRK_FRC_BIT = 12;
  localparam int PTD_BIAS_LSB    = 8;
  localparam int PTD_POLE_LSB    = 6;
  // buck force-pwm bit, own override enable bit
  localparam int PTD_PWM_BIT     = 4;
  localparam int PTD_OVR_EN_BIT  = 0;

  localparam logic [6:0] PTD_RST_COMP_FORCE = 7'h00;
  localparam logic       PTD_RST_OVR_EN     = 1'b0;
  localparam logic       PTD_RST_TRK_FRC    = 1'b1;
  localparam logic [1:0] PTD_RST_BIAS       = 2'h2;
  localparam logic [1:0] PTD_RST_POLE       = 2'h0;
  localparam logic [2:0] PTD_RST_PWM        = 3'h0;

endpackage

// ### design/ptd_regs.sv
// Purpose: test and debug register bank on a classic Wishbone slave
// Assumes: state and gain inputs come from logic on clk_i; comparator
//          inputs are raw analogue-side levels and get synchronised
// Notes:   every access is answered one cycle after it is presented
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module ptd_regs (
  input  wire logic                           clk_i,
  input  wire logic                           rst_i,
  input  wire logic                           cyc_i,
  input  wire logic                           stb_i,
  input  wire logic                           we_i,
  input  wire logic [ptd_pkg::PTD_ADR_W-1:0]  adr_i,
  input  wire logic [3:0]                     sel_i,
  input  wire logic [ptd_pkg::PTD_DAT_W-1:0]  dat_i,
  output logic      [ptd_pkg::PTD_DAT_W-1:0]  dat_o,
  output logic                                ack_o,
  input  wire logic [ptd_pkg::PTD_NCOMP-1:0]  comp_raw_i,
  output logic      [ptd_pkg::PTD_NCOMP-1:0]  debounce_in_o,
  input  wire logic [2:0]                     bus_supply_state_i,
  input  wire logic [2:0]                     charger_state_i,
  input  wire logic [3:0]                     main_power_state_i,
  input  wire logic                           key_unlocked_i,
  input  wire logic                           loop_locked_i,
  input  wire logic [ptd_pkg::PTD_GAIN_W-1:0] loop_tracking_gain_i,
  output logic      [ptd_pkg::PTD_GAIN_W-1:0] loop_gain_o,
  output logic      [1:0]                     loop_bias_setting_o,
  output logic      [1:0]                     loop_pole_adjust_o,
  input  wire logic [2:0]                     pwm_force_clear_i,
  output logic      [2:0]                     buck_pwm_force_o
);
  import ptd_pkg::*;

  // all properties below sample on clk_i and rest while reset is held
  default clocking ptd_cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic [PTD_NCOMP-1:0]  comp_meta_q;
  logic [PTD_NCOMP-1:0]  comp_sync_q;
  logic [PTD_NCOMP-1:0]  comp_force_q;
  logic                  ovr_en_q;
  logic                  trk_frc_q;
  logic [1:0]            bias_q;
  logic [1:0]            pole_q;
  logic [2:0]            pwm_q;
  logic [2:0]            pwm_d;
  logic                  ack_q;
  logic [31:0]           dat_q;
  logic [PTD_NCOMP-1:0]  dbn_q;
  logic [PTD_GAIN_W-1:0] gain_q;

  // bus decode
  wire       req    = cyc_i && stb_i && !ack_q;
  wire [7:0] idx    = adr_i[9:2];
  wire       wr     = req && we_i;
  wire       wr_b0  = wr && sel_i[0];
  wire       wr_b1  = wr && sel_i[1];
  wire       hit_co = idx == PTD_IDX_COMP_OVR;
  wire       hit_sm = idx == PTD_IDX_SM_READ;
  wire       hit_lt = idx == PTD_IDX_LOOP_TEST;
  wire       hit_oc = idx == PTD_IDX_OVR_CTRL;
  wire       hit_b1 = idx == PTD_IDX_BUCK_ONE;
  wire       hit_b3 = idx == PTD_IDX_BUCK_THR;
  wire       hit_b4 = idx == PTD_IDX_BUCK_FOUR;
  // locked key turns a protected write into a plain ack
  wire       key_wr = key_unlocked_i && hit_lt;

  function automatic logic [15:0] comp_word(input logic [6:0] c);
    comp_word = {c[6:4], 1'b0, c[3:0], 8'h00};
  endfunction

  // raw levels, never the stored force value
  wire [15:0] rd_co = comp_word(comp_sync_q);
  wire [15:0] rd_sm = {5'h00, bus_supply_state_i, 1'b0,
                       charger_state_i,
                       main_power_state_i};
  wire [15:0] rd_lt = {3'h0, trk_frc_q, 2'h0, bias_q, pole_q, 6'h00};
  wire [15:0] rd_oc = {15'h0000, ovr_en_q};
  wire [2:0]  pwm_rd_sel = {hit_b4, hit_b3, hit_b1};
  wire [15:0] rd_bk = {11'h000, |(pwm_q & pwm_rd_sel), 4'h0};
  wire [15:0] rd_mux = hit_co ? rd_co :
                       hit_sm ? rd_sm :
                       hit_lt ? rd_lt :
                       hit_oc ? rd_oc :
                       (|pwm_rd_sel) ? rd_bk : 16'h0000;

  // clear from the state machine wins over a same-cycle write
  wire [2:0] pwm_wr = {wr_b0 && hit_b4, wr_b0 && hit_b3, wr_b0 && hit_b1};
  always_comb begin
    pwm_d = pwm_q;
    for (int i = 0; i < 3; i++) begin
      if (pwm_wr[i]) begin
        pwm_d[i] = dat_i[PTD_PWM_BIT];
      end
      if (pwm_force_clear_i[i]) begin
        pwm_d[i] = 1'b0;
      end
    end
  end

  // first stage is read only by the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      comp_meta_q <= '0;
      comp_sync_q <= '0;
    end else begin
      comp_meta_q <= comp_raw_i;
      comp_sync_q <= comp_meta_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ack_q <= req;
      if (req && !we_i) begin
        dat_q <= {16'h0000, rd_mux};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      comp_force_q <= PTD_RST_COMP_FORCE;
      ovr_en_q     <= PTD_RST_OVR_EN;
    end else begin
      if (wr_b1 && hit_co) begin
        comp_force_q <= {dat_i[PTD_COMP_HI_LSB +: 3],
                         dat_i[PTD_COMP_LO_LSB +: 4]};
      end
      if (wr_b0 && hit_oc) begin
        ovr_en_q <= dat_i[PTD_OVR_EN_BIT];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trk_frc_q <= PTD_RST_TRK_FRC;
      bias_q    <= PTD_RST_BIAS;
      pole_q    <= PTD_RST_POLE;
    end else begin
      if (wr_b1 && key_wr) begin
        trk_frc_q <= dat_i[PTD_TRK_FRC_BIT];
        bias_q    <= dat_i[PTD_BIAS_LSB +: 2];
      end
      if (wr_b0 && key_wr) begin
        pole_q <= dat_i[PTD_POLE_LSB +: 2];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_q  <= PTD_RST_PWM;
      dbn_q  <= '0;
      gain_q <= '0;
    end else begin
      pwm_q  <= pwm_d;
      dbn_q  <= ovr_en_q ? comp_force_q : comp_sync_q;
      // zero gain keeps the loop from hunting while it is out of lock with tracking force set
      gain_q <= (trk_frc_q && !loop_locked_i) ? '0
                                             : loop_tracking_gain_i;
    end
  end

  assign ack_o               = ack_q;
  assign dat_o               = dat_q;
  assign debounce_in_o       = dbn_q;
  assign loop_gain_o         = gain_q;
  assign loop_bias_setting_o = bias_q;
  assign loop_pole_adjust_o  = pole_q;
  assign buck_pwm_force_o    = pwm_q;

  // each access is taken on one edge and answered on the next
  sequence s_read(logic [7:0] ix);
    req && !we_i && idx == ix ##1 ack_o;
  endsequence

  sequence s_read_unmapped;
    req && !we_i && !(hit_co || hit_sm || hit_lt || hit_oc) &&
      !(|pwm_rd_sel) ##1 ack_o;
  endsequence

  sequence s_write_lo(logic [7:0] ix);
    wr_b0 && idx == ix ##1 ack_o;
  endsequence

  sequence s_write_hi(logic [7:0] ix);
    wr_b1 && idx == ix ##1 ack_o;
  endsequence

  // unlocked protected writes, split by byte lane, key sampled at the edge that takes them
  sequence s_unlocked_lo;
    wr_b0 && key_wr ##1 ack_o;
  endsequence

  sequence s_unlocked_hi;
    wr_b1 && key_wr ##1 ack_o;
  endsequence

  a_ack_answer: assert property (req |=> ack_o)
    else $error("access not answered in the next cycle");

  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  a_read_hold: assert property (
    !(req && !we_i) |=> $stable(dat_o))
    else $error("read data moved without a read");

  a_upper_zero: assert property (
    ack_o |-> dat_o[31:16] == 16'h0000)
    else $error("upper read data lanes not zero");

  a_unmapped_read: assert property (
    s_read_unmapped |-> dat_o == '0)
    else $error("unmapped index did not read zero");

  a_comp_raw_read: assert property (
    s_read(PTD_IDX_COMP_OVR) |-> dat_o[15:0] == comp_word($past(comp_sync_q)))
    else $error("override readback not raw level");

  // raw levels pass exactly two flip-flops before anything reads them
  a_comp_sync: assert property (
    !$past(rst_i) && !$past(rst_i, 2) |->
      comp_sync_q == $past(comp_raw_i, 2))
    else $error("comparator synchroniser depth wrong");

  a_override_drive: assert property (
    $past(ovr_en_q) && !$past(rst_i) |->
      debounce_in_o == $past(comp_force_q))
    else $error("override not driving debounce");

  a_override_bypass: assert property (
    !$past(ovr_en_q) && !$past(rst_i) |->
      debounce_in_o == $past(comp_sync_q))
    else $error("comparators not reaching debounce");

  a_force_capture: assert property (
    s_write_hi(PTD_IDX_COMP_OVR) |->
      comp_force_q == {$past(dat_i[PTD_COMP_HI_LSB +: 3]),
                       $past(dat_i[PTD_COMP_LO_LSB +: 4])})
    else $error("force values not captured");

  a_enable_write: assert property (
    s_write_lo(PTD_IDX_OVR_CTRL) |->
      ovr_en_q == $past(dat_i[PTD_OVR_EN_BIT]))
    else $error("override enable write lost");

  a_bus_state_read: assert property (
    s_read(PTD_IDX_SM_READ) |->
      dat_o[10:8] == $past(bus_supply_state_i) && dat_o[15:11] == 5'h00)
    else $error("bus supply state readback wrong");

  a_charger_read: assert property (
    s_read(PTD_IDX_SM_READ) |-> dat_o[6:4] == $past(charger_state_i))
    else $error("charger state readback wrong");

  a_main_read: assert property (
    s_read(PTD_IDX_SM_READ) |-> dat_o[3:0] == $past(main_power_state_i))
    else $error("main power state readback wrong");

  a_gain_hold: assert property (
    trk_frc_q && !loop_locked_i |=> loop_gain_o == '0)
    else $error("tracking gain not held at zero");

  a_gain_pass: assert property (
    !trk_frc_q |=> loop_gain_o == $past(loop_tracking_gain_i))
    else $error("tracking gain not passed through");

  a_gain_locked: assert property (
    loop_locked_i |=> loop_gain_o == $past(loop_tracking_gain_i))
    else $error("tracking gain not released on lock");

  a_loop_write: assert property (
    s_unlocked_hi |->
      trk_frc_q == $past(dat_i[PTD_TRK_FRC_BIT]) &&
      loop_bias_setting_o == $past(dat_i[PTD_BIAS_LSB +: 2]))
    else $error("unlocked loop test write lost");

  a_loop_read: assert property (
    s_read(PTD_IDX_LOOP_TEST) |->
      dat_o[PTD_TRK_FRC_BIT] == $past(trk_frc_q) &&
      dat_o[PTD_BIAS_LSB +: 2] == $past(loop_bias_setting_o) &&
      dat_o[PTD_POLE_LSB +: 2] == $past(loop_pole_adjust_o))
    else $error("loop test readback wrong");

  a_pole_write: assert property (
    s_unlocked_lo |->
      loop_pole_adjust_o == $past(dat_i[PTD_POLE_LSB +: 2]))
    else $error("pole adjust write lost");

  // writes only count where no clear arrives in the same cycle
  a_pwm_set: assert property (
    wr_b0 && hit_b3 && !pwm_force_clear_i[1] |=>
      buck_pwm_force_o[1] == $past(dat_i[PTD_PWM_BIT]))
    else $error("force pwm write lost");

  a_buck_one_set: assert property (
    wr_b0 && hit_b1 && !pwm_force_clear_i[0] |=>
      buck_pwm_force_o[0] == $past(dat_i[PTD_PWM_BIT]))
    else $error("buck one force pwm write lost");

  a_buck_four_set: assert property (
    wr_b0 && hit_b4 && !pwm_force_clear_i[2] |=>
      buck_pwm_force_o[2] == $past(dat_i[PTD_PWM_BIT]))
    else $error("buck four force pwm write lost");

  a_buck_read: assert property (
    s_read(PTD_IDX_BUCK_THR) |->
      dat_o[PTD_PWM_BIT] == $past(buck_pwm_force_o[1]))
    else $error("force pwm readback wrong");

  a_pwm_hold: assert property (
    !(wr_b0 && (|pwm_rd_sel)) && pwm_force_clear_i == 3'h0 |=>
      $stable(buck_pwm_force_o))
    else $error("force pwm moved without write or clear");

  // the state machine outranks software, even in the same cycle
  a_pwm_clear: assert property (
    pwm_force_clear_i != 3'h0 |=>
      (buck_pwm_force_o & $past(pwm_force_clear_i)) == 3'h0)
    else $error("force pwm not cleared by state machine");

  a_key_protect: assert property (
    wr && hit_lt && !key_unlocked_i |=>
      $stable(trk_frc_q) && $stable(bias_q) && $stable(pole_q))
    else $error("protected field written while locked");

endmodule
`default_nettype wire
